//--- core/gpio_pkg.sv
// shared constants and carriers for the eight-bit shared io port
package gpio_pkg;

    // ============================================================
    // sizes
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ============================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_OUT = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_IN = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
    localparam logic [7:0] OFS_EDGE = 8'h10;
    localparam logic [7:0] OFS_FLAG = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_ALT = 8'h1c;

    // ============================================================
    // field positions of the alternate-function register
    localparam int ALT_TMR_LSB = 0;
    localparam int ALT_GAIN_LSB = 8;
    localparam int ALT_FREEZE_BIT = 11;
    localparam int GAIN_W = 3;
    localparam int GAIN_PIN_LSB = 5;
    localparam int FREEZE_PIN = 7;

    // ============================================================
    // values after reset
    localparam logic [7:0] RST_OUT = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_EDGE = 8'h00;
    localparam logic [7:0] RST_FLAG = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_PULL = 8'hff;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // ============================================================
    // carriers
    typedef struct packed {
        logic freeze;
        logic [2:0] gain_drv;
        logic [7:0] tmr_drv;
    } alt_cfg_s;

    localparam alt_cfg_s RST_ALT = '{freeze: 1'b0, gain_drv: 3'h0, tmr_drv: 8'h00};

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } pin_drive_s;

    typedef enum logic {ST_IDLE, ST_ANSWER} apb_state_e;

endpackage : gpio_pkg

//--- core/pin_edge_sync.sv
// two-flop pin synchroniser with per-bit rise and fall detection
`timescale 1ns/100ps

module pin_edge_sync #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // ============================================================
    // per-bit synchroniser; the first flop feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    meta_r[i] <= 1'b1;
                    sync_r[i] <= 1'b1;
                    prev_r[i] <= 1'b1;
                end else begin
                    meta_r[i] <= pin_in[i];
                    sync_r[i] <= meta_r[i];
                    prev_r[i] <= sync_r[i];
                end
            end
            assign rise[i] = sync_r[i] & ~prev_r[i];
            assign fall[i] = ~sync_r[i] & prev_r[i];
        end
    endgenerate

    assign level = sync_r;

endmodule : pin_edge_sync

//--- core/apb_slave_port.sv
// apb handshake: one wait state, registered read data and error
`timescale 1ns/100ps

module apb_slave_port (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] rdata_mux,
    input wire logic addr_bad,
    output logic wr_stb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);

    gpio_pkg::apb_state_e state_r;
    gpio_pkg::apb_state_e state_nxt;
    logic enter_w;

    // ============================================================
    // answer one cycle after the access phase opens
    assign enter_w = psel & penable & (state_r == gpio_pkg::ST_IDLE);
    assign wr_stb = psel & penable & pwrite & (state_r == gpio_pkg::ST_ANSWER);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            gpio_pkg::ST_IDLE: begin
                if (enter_w) begin
                    state_nxt = gpio_pkg::ST_ANSWER;
                end
            end
            gpio_pkg::ST_ANSWER: begin
                state_nxt = gpio_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = gpio_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r <= gpio_pkg::ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= gpio_pkg::RST_RDATA;
        end else begin
            state_r <= state_nxt;
            pready <= enter_w;
            pslverr <= enter_w & addr_bad;
            prdata <= (enter_w && !pwrite) ? rdata_mux : gpio_pkg::RST_RDATA;
        end
    end

endmodule : apb_slave_port

//--- core/shared_io_port.sv
// eight-bit shared io port with edge interrupts and alternate functions
`timescale 1ns/100ps

// Function
// - eight-bit bidirectional port, pins raise interrupts
// - each pin interrupt enabled on its own
// - software picks rising or falling edge
// - reset: all inputs, pull-ups on, no drivers
// - drive only by direction bit or owning function
// - pin n: interrupt n; pairs feed timers 0-3
// - pins 5-7 gain bits; pin 7 may freeze
module shared_io_port #(
    parameter int PORT_W = gpio_pkg::PORT_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [PORT_W-1:0] shared_io_pins_in,
    output logic [PORT_W-1:0] shared_io_pins_out,
    output logic [PORT_W-1:0] shared_io_pins_oe,
    output logic [PORT_W-1:0] shared_io_pins_pull,
    input wire logic [PORT_W-1:0] timer_drive_val,
    input wire logic [PORT_W-1:0] timer_drive_en,
    output logic [PORT_W-1:0] timer_inputs,
    input wire logic [2:0] gain_ctrl_bits,
    output logic gain_freeze,
    output logic irq
);

    // ============================================================
    // register state
    logic [PORT_W-1:0] out_r;
    logic [PORT_W-1:0] dir_r;
    logic [PORT_W-1:0] irq_en_r;
    logic [PORT_W-1:0] edge_fall_r;
    logic [PORT_W-1:0] flag_r;
    logic [PORT_W-1:0] flag_nxt;
    logic [PORT_W-1:0] mask_r;
    gpio_pkg::alt_cfg_s alt_r;
    gpio_pkg::pin_drive_s drive_r;
    gpio_pkg::pin_drive_s drive_nxt;
    logic [PORT_W-1:0] timer_in_r;
    logic freeze_r;
    logic irq_r;

    // ============================================================
    // pin sampling
    logic [PORT_W-1:0] pin_level;
    logic [PORT_W-1:0] pin_rise;
    logic [PORT_W-1:0] pin_fall;

    pin_edge_sync #(
        .W(PORT_W)
    ) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .pin_in(shared_io_pins_in),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ============================================================
    // bus decode
    logic wr_stb;
    logic sel_out;
    logic sel_dir;
    logic sel_in;
    logic sel_irq_en;
    logic sel_edge;
    logic sel_flag;
    logic sel_mask;
    logic sel_alt;
    logic addr_bad;
    logic [31:0] rdata_mux;
    logic [PORT_W-1:0] wdata_port;
    logic [PORT_W-1:0] flag_clr;

    assign sel_out = (paddr == gpio_pkg::OFS_OUT);
    assign sel_dir = (paddr == gpio_pkg::OFS_DIR);
    assign sel_in = (paddr == gpio_pkg::OFS_IN);
    assign sel_irq_en = (paddr == gpio_pkg::OFS_IRQ_EN);
    assign sel_edge = (paddr == gpio_pkg::OFS_EDGE);
    assign sel_flag = (paddr == gpio_pkg::OFS_FLAG);
    assign sel_mask = (paddr == gpio_pkg::OFS_MASK);
    assign sel_alt = (paddr == gpio_pkg::OFS_ALT);
    assign addr_bad = ~(sel_out | sel_dir | sel_in | sel_irq_en | sel_edge |
                        sel_flag | sel_mask | sel_alt);
    assign wdata_port = pwdata[PORT_W-1:0];

    always_comb begin
        rdata_mux = 32'h0000_0000;
        if (sel_out) begin
            rdata_mux[PORT_W-1:0] = out_r;
        end else if (sel_dir) begin
            rdata_mux[PORT_W-1:0] = dir_r;
        end else if (sel_in) begin
            rdata_mux[PORT_W-1:0] = pin_level;
        end else if (sel_irq_en) begin
            rdata_mux[PORT_W-1:0] = irq_en_r;
        end else if (sel_edge) begin
            rdata_mux[PORT_W-1:0] = edge_fall_r;
        end else if (sel_flag) begin
            rdata_mux[PORT_W-1:0] = flag_r;
        end else if (sel_mask) begin
            rdata_mux[PORT_W-1:0] = mask_r;
        end else if (sel_alt) begin
            rdata_mux[gpio_pkg::ALT_FREEZE_BIT:0] = alt_r;
        end
    end

    apb_slave_port u_apb (
        .mclk(mclk),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .rdata_mux(rdata_mux),
        .addr_bad(addr_bad),
        .wr_stb(wr_stb),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr)
    );

    // ============================================================
    // configuration registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            out_r <= gpio_pkg::RST_OUT;
            dir_r <= gpio_pkg::RST_DIR;
            irq_en_r <= gpio_pkg::RST_IRQ_EN;
            edge_fall_r <= gpio_pkg::RST_EDGE;
            mask_r <= gpio_pkg::RST_MASK;
            alt_r <= gpio_pkg::RST_ALT;
        end else if (wr_stb) begin
            if (sel_out) begin
                out_r <= wdata_port;
            end
            if (sel_dir) begin
                dir_r <= wdata_port;
            end
            if (sel_irq_en) begin
                irq_en_r <= wdata_port;
            end
            if (sel_edge) begin
                edge_fall_r <= wdata_port;
            end
            if (sel_mask) begin
                mask_r <= wdata_port;
            end
            if (sel_alt) begin
                alt_r <= pwdata[gpio_pkg::ALT_FREEZE_BIT:0];
            end
        end
    end

    // ============================================================
    // interrupt flags: pin n sets flag n; a new edge beats a clear
    logic [PORT_W-1:0] edge_hit;
    logic [PORT_W-1:0] mask_nxt;

    assign flag_clr = (wr_stb && sel_flag) ? wdata_port : '0;
    assign edge_hit = irq_en_r & ((pin_rise & ~edge_fall_r) | (pin_fall & edge_fall_r));
    assign flag_nxt = (flag_r & ~flag_clr) | edge_hit;
    // irq tracks a mask write in the same cycle, never one cycle stale
    assign mask_nxt = (wr_stb && sel_mask) ? wdata_port : mask_r;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            flag_r <= gpio_pkg::RST_FLAG;
            irq_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            irq_r <= |(flag_nxt & mask_nxt);
        end
    end

    // ============================================================
    // pin drive; gain bits outrank timers, timers outrank the port
    logic [PORT_W-1:0] gain_own;
    logic [PORT_W-1:0] gain_val;
    logic [PORT_W-1:0] tmr_own;

    genvar g;
    generate
        for (g = 0; g < PORT_W; g++) begin : g_pin
            if (g >= gpio_pkg::GAIN_PIN_LSB && g < gpio_pkg::GAIN_PIN_LSB + gpio_pkg::GAIN_W)
            begin : g_gain
                // freeze stops gain bit 2 from driving pin 7; its direction bit or timer can still drive it
                assign gain_own[g] = alt_r.gain_drv[g - gpio_pkg::GAIN_PIN_LSB] &
                                     ~(alt_r.freeze && g == gpio_pkg::FREEZE_PIN);
                assign gain_val[g] = gain_ctrl_bits[g - gpio_pkg::GAIN_PIN_LSB];
            end else begin : g_plain
                assign gain_own[g] = 1'b0;
                assign gain_val[g] = 1'b0;
            end
            assign tmr_own[g] = alt_r.tmr_drv[g] & timer_drive_en[g];
        end
    endgenerate

    always_comb begin
        drive_nxt.oe = dir_r | tmr_own | gain_own;
        drive_nxt.out = (gain_own & gain_val) | (~gain_own & tmr_own & timer_drive_val) |
                        (~gain_own & ~tmr_own & out_r);
        drive_nxt.pull = ~drive_nxt.oe;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            drive_r.out <= gpio_pkg::RST_OUT;
            drive_r.oe <= gpio_pkg::RST_DIR;
            drive_r.pull <= gpio_pkg::RST_PULL;
            timer_in_r <= '0;
            freeze_r <= 1'b0;
        end else begin
            drive_r <= drive_nxt;
            timer_in_r <= pin_level;
            freeze_r <= alt_r.freeze & pin_level[gpio_pkg::FREEZE_PIN];
        end
    end

    // ============================================================
    // outputs
    assign shared_io_pins_out = drive_r.out;
    assign shared_io_pins_oe = drive_r.oe;
    assign shared_io_pins_pull = drive_r.pull;
    assign timer_inputs = timer_in_r;
    assign gain_freeze = freeze_r;
    assign irq = irq_r;

    // ============================================================
    // checks
    AST_RESET_STATE: assert property (@(posedge mclk)
        !resetn |=> (shared_io_pins_oe == 8'h00) && (shared_io_pins_pull == 8'hff))
        else $error("port not released to pulled-up inputs by reset");

    AST_DRIVE_CAUSE: assert property (@(posedge mclk) disable iff (!resetn)
        ((shared_io_pins_oe & ~($past(dir_r) | $past(tmr_own) | $past(gain_own))) == 8'h00))
        else $error("pin driven without direction bit or owning function");

    AST_RISE_SETS: assert property (@(posedge mclk) disable iff (!resetn)
        (pin_rise[0] && irq_en_r[0] && !edge_fall_r[0]) |=> flag_r[0])
        else $error("rising edge did not set its flag");

    AST_FALL_SETS: assert property (@(posedge mclk) disable iff (!resetn)
        (pin_fall[7] && irq_en_r[7] && edge_fall_r[7]) |=> flag_r[7])
        else $error("falling edge did not set its flag");

    AST_ENABLE_GATES: assert property (@(posedge mclk) disable iff (!resetn)
        ((flag_r & ~$past(flag_r) & ~$past(irq_en_r)) == 8'h00))
        else $error("disabled interrupt raised a flag");

    AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (!resetn)
        (flag_r[3] && !(wr_stb && sel_flag && wdata_port[3])) [*2] |=> flag_r[3])
        else $error("flag dropped without a software clear");

    AST_SYNC_DELAY: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn, 3) |-> (pin_level == $past(shared_io_pins_in, 2)))
        else $error("pin level not two flops behind the pin");

    AST_TIMER_ROUTE: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) |-> (timer_inputs == $past(pin_level)))
        else $error("timer inputs not following their pins");

    AST_GAIN_DRIVE: assert property (@(posedge mclk) disable iff (!resetn)
        (alt_r.gain_drv[0] && !alt_r.freeze) |=>
            shared_io_pins_oe[5] && (shared_io_pins_out[5] == $past(gain_ctrl_bits[0])))
        else $error("gain bit 0 not driven on pin 5");

    AST_FREEZE_IN: assert property (@(posedge mclk) disable iff (!resetn)
        (alt_r.freeze && alt_r.gain_drv[2] && !dir_r[7] && !tmr_own[7]) |=>
            !shared_io_pins_oe[7])
        else $error("pin 7 driven while used as freeze input");

    AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) |-> (irq == |(flag_r & mask_r)))
        else $error("interrupt output disagrees with masked flags");

    AST_APB_ANSWER: assert property (@(posedge mclk) disable iff (!resetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("bus answer not one cycle after access phase");

    // ============================================================
    // drive, edge, flag clear, freeze, reset and read-idle checks
    AST_PULL_INV: assert property (@(posedge mclk) disable iff (!resetn)
        (shared_io_pins_pull == ~shared_io_pins_oe))
        else $error("pull-up not the inverse of the drive enable");

    AST_DIR_DRIVES: assert property (@(posedge mclk) disable iff (!resetn)
        ((shared_io_pins_oe & $past(dir_r)) == $past(dir_r)))
        else $error("direction bit set but pin not driven");

    AST_PORT_VALUE: assert property (@(posedge mclk) disable iff (!resetn)
        (dir_r[0] && !tmr_own[0]) |=> (shared_io_pins_out[0] == $past(out_r[0])))
        else $error("port value not on a driven pin");

    AST_TIMER_DRIVE: assert property (@(posedge mclk) disable iff (!resetn)
        tmr_own[0] |=>
            shared_io_pins_oe[0] && (shared_io_pins_out[0] == $past(timer_drive_val[0])))
        else $error("timer drive not on pin 0");

    AST_WRONG_RISE: assert property (@(posedge mclk) disable iff (!resetn)
        ((flag_r & ~$past(flag_r) & $past(pin_rise) & $past(edge_fall_r)) == 8'h00))
        else $error("rising edge set a flag that waits for a fall");

    AST_WRONG_FALL: assert property (@(posedge mclk) disable iff (!resetn)
        ((flag_r & ~$past(flag_r) & $past(pin_fall) & ~$past(edge_fall_r)) == 8'h00))
        else $error("falling edge set a flag that waits for a rise");

    AST_CLEAR_WORKS: assert property (@(posedge mclk) disable iff (!resetn)
        (wr_stb && sel_flag && wdata_port[4] && !pin_rise[4] && !pin_fall[4]) |=> !flag_r[4])
        else $error("software clear did not drop the flag");

    AST_GAIN_MID: assert property (@(posedge mclk) disable iff (!resetn)
        alt_r.gain_drv[1] |=>
            shared_io_pins_oe[6] && (shared_io_pins_out[6] == $past(gain_ctrl_bits[1])))
        else $error("gain bit 1 not driven on pin 6");

    AST_GAIN_HIGH: assert property (@(posedge mclk) disable iff (!resetn)
        (alt_r.gain_drv[2] && !alt_r.freeze) |=>
            shared_io_pins_oe[7] && (shared_io_pins_out[7] == $past(gain_ctrl_bits[2])))
        else $error("gain bit 2 not driven on pin 7");

    AST_FREEZE_LEVEL: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) |-> (gain_freeze == ($past(alt_r.freeze) && $past(pin_level[7]))))
        else $error("freeze output not following pin 7");

    AST_RESET_OUTS: assert property (@(posedge mclk)
        !resetn |=> !irq && !gain_freeze && (timer_inputs == 8'h00) &&
            (shared_io_pins_out == 8'h00))
        else $error("outputs not cleared by reset");

    AST_READ_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
        !pready |-> (prdata == 32'h0000_0000) && !pslverr)
        else $error("read data or error outside an answer");

endmodule : shared_io_port

//--- test/pin_board.sv
// board-side model of the eight shared pins
`timescale 1ns/100ps

module pin_board (
    input wire logic mclk,
    input wire logic [7:0] drv_val,
    input wire logic [7:0] drv_en,
    input wire logic [7:0] dut_out,
    input wire logic [7:0] dut_oe,
    input wire logic [7:0] dut_pull,
    output logic [7:0] level
);
    // ============================================================
    // wire resolution
    logic [7:0] churn_r = 8'h00;

    // undriven, unpulled pins wander so a stale value never looks valid
    always @(posedge mclk) churn_r <= ~churn_r;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (dut_oe[i]) level[i] = dut_out[i];
            else if (drv_en[i]) level[i] = drv_val[i];
            else if (dut_pull[i]) level[i] = 1'b1;
            else level[i] = churn_r[i];
        end
    end
endmodule : pin_board

//--- test/tb_top.sv
// self-checking bench for the shared io port
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module tb_top;
    // ============================================================
    // signals
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] tdv = 8'h00;
    logic [7:0] tde = 8'h00;
    logic [2:0] gbits = 3'h0;
    logic [7:0] bval = 8'hff;
    logic [7:0] ben = 8'h00;
    logic pready, pslverr, gfrz, irq;
    logic [31:0] prdata;
    logic [7:0] pout, poe, ppull, pin, tin;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 67;
    logic [33:0] q[$];
    logic [7:0] en, e, c, flag;

    always #12.5 mclk = ~mclk;

    shared_io_port shared_io_port_inst (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .shared_io_pins_in(pin),
        .shared_io_pins_out(pout), .shared_io_pins_oe(poe), .shared_io_pins_pull(ppull),
        .timer_drive_val(tdv), .timer_drive_en(tde), .timer_inputs(tin),
        .gain_ctrl_bits(gbits), .gain_freeze(gfrz), .irq(irq));

    pin_board pin_board_inst (.mclk(mclk), .drv_val(bval), .drv_en(ben), .dut_out(pout),
        .dut_oe(poe), .dut_pull(ppull), .level(pin));

    // ============================================================
    // closing and watchdog
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            end_of_test();
        end
    end

    // ============================================================
    // apb master and response watcher
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] x, input logic err);
        @(posedge mclk);
        q.push_back({is_wr, err, x});
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk iff pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, x, 1'b0);
    endtask : rd

    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wait_n

    // reads compare data, every answer compares the error flag
    always @(posedge mclk) begin
        logic [33:0] n;
        if (pready) begin
            if (q.size() == 0) begin
                num_errors++;
                $display("[FAIL] %0t unexpected answer", $time);
            end else begin
                n = q.pop_front();
                `CHK(pslverr, n[32])
                if (!n[33]) `CHK(prdata, n[31:0])
            end
        end
    end

    // ============================================================
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        wait_n(1);
        `CHK(poe, 8'h00)
        `CHK(ppull, 8'hff)
        `CHK(irq, 1'b0)
        `CHK(gfrz, 1'b0)
        rd(gpio_pkg::OFS_DIR, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h24, 32'hff, 32'h0, 1'b1);
        $display("test reset done");

        wr(gpio_pkg::OFS_OUT, 32'h5a);
        wr(gpio_pkg::OFS_DIR, 32'h0f);
        wait_n(2);
        `CHK(poe, 8'h0f)
        `CHK(ppull, 8'hf0)
        `CHK(pout & 8'h0f, 8'h0a)
        @(posedge mclk);
        ben <= 8'hff;
        bval <= 8'h3c;
        wait_n(4);
        rd(gpio_pkg::OFS_IN, 32'h3a);
        wait_n(1);
        `CHK(tin, 8'h3a)
        wr(gpio_pkg::OFS_IN, 32'hff);
        rd(gpio_pkg::OFS_IN, 32'h3a);
        wr(gpio_pkg::OFS_DIR, 32'h0);
        $display("test direction done");

        for (int k = 0; k < 4; k++) begin
            en = 8'($random(seed));
            e = 8'($random(seed));
            c = 8'($random(seed));
            @(posedge mclk);
            bval <= 8'hff;
            wait_n(4);
            wr(gpio_pkg::OFS_FLAG, 32'hff);
            wr(gpio_pkg::OFS_IRQ_EN, {24'h0, en});
            wr(gpio_pkg::OFS_EDGE, {24'h0, e});
            wr(gpio_pkg::OFS_MASK, 32'hff);
            @(posedge mclk);
            bval <= 8'h00;
            wait_n(4);
            flag = e & en;
            rd(gpio_pkg::OFS_FLAG, {24'h0, flag});
            wait_n(1);
            `CHK(irq, |flag)
            @(posedge mclk);
            bval <= 8'hff;
            wait_n(4);
            flag = flag | (~e & en);
            rd(gpio_pkg::OFS_FLAG, {24'h0, flag});
            wr(gpio_pkg::OFS_MASK, 32'h0);
            wait_n(3);
            `CHK(irq, 1'b0)
            wr(gpio_pkg::OFS_FLAG, {24'h0, c});
            flag = flag & ~c;
            rd(gpio_pkg::OFS_FLAG, {24'h0, flag});
            wr(gpio_pkg::OFS_MASK, 32'hff);
            wait_n(3);
            `CHK(irq, |flag)
        end
        $display("test interrupts done");

        @(posedge mclk);
        tde <= 8'h01;
        tdv <= 8'h01;
        gbits <= 3'h5;
        ben <= 8'h00;
        wr(gpio_pkg::OFS_ALT, 32'h0000_0701);
        wait_n(2);
        `CHK(poe, 8'he1)
        `CHK(pout & 8'he1, 8'ha1)
        wr(gpio_pkg::OFS_ALT, 32'h0000_0f01);
        @(posedge mclk);
        ben <= 8'h80;
        bval <= 8'h00;
        wait_n(4);
        `CHK(poe, 8'h61)
        `CHK(gfrz, 1'b0)
        @(posedge mclk);
        bval <= 8'h80;
        wait_n(4);
        `CHK(gfrz, 1'b1)
        wr(gpio_pkg::OFS_ALT, 32'h0);
        wait_n(2);
        `CHK(poe, 8'h00)
        $display("test alternate done");
        end_of_test();
    end
endmodule : tb_top
